// *** pkg/rsc_defines.vh ***
// constants for the ring setup command handler
//
// Contract
// - define ring always accepted, executed once ring stopped, complete or not defined
// - ring pointers keep upper bits fixed, lower bits wrap at ring length; 0100 = 128 bytes
// - differing read and write pointers: fetch at read pointer, write status at write pointer
// - indicate-after-copy transmit ring reports only the local copy outcome
// - setup commands accepted any time from command register or descriptor ring; here a go written while a command is pending is ignored
// - set destination configures DMA destination ring; define ring 00 the source ring
// - set destination with ready bit moves destination ring to ready, else not ready; here the ready bit loads the local start address instead
// - read low from bits 47:35, high from 31:16, write low from 15:3
// - local start address high from bits 31:16, low from 15:3, bits 2:0 zero
// - local addresses keep upper start bits, region sized by code; 010 = 32K bytes
// - bit pair 00 normal, 01 invalid, 10 local, 11 local early indication rings 0-3
// - define ring with ready bit goes ready and fetches, else complete
// - pointers mark next descriptor and wrap at the programmed modulo length
`ifndef RSC_DEFINES_VH
`define RSC_DEFINES_VH

// apb register byte addresses
`define RSC_ADDR_CMD_HI     12'h000
`define RSC_ADDR_CMD_LO     12'h004
`define RSC_ADDR_CTRL       12'h008
`define RSC_ADDR_STATUS     12'h00c
`define RSC_ADDR_SEL        12'h010
`define RSC_ADDR_RD_PTR     12'h014
`define RSC_ADDR_WR_PTR     12'h018
`define RSC_ADDR_LOC_START  12'h01c
`define RSC_ADDR_RING_PARAM 12'h020
`define RSC_ADDR_LOC_PARAM  12'h024
`define RSC_ADDR_STATE      12'h028

// command word fields (64-bit word, hi word holds 63:32)
`define RSC_OPC_HI   55
`define RSC_OPC_LO   52
`define RSC_OPC_DEF  4'h0
`define RSC_OPC_DST  4'h1
// bits 61:56 of every ring command word; bit 63 set, bit 62 free
`define RSC_CMD_TAG  6'h3e
`define RSC_BIT_L    54
`define RSC_BIT_I    53
`define RSC_BIT_R    51
`define RSC_RING_HI  50
`define RSC_RING_LO  48
`define RSC_RDL_HI   47
`define RSC_RDL_LO   35
`define RSC_PH_HI    31
`define RSC_PH_LO    16
`define RSC_WRL_HI   15
`define RSC_WRL_LO   3

// ring states
`define RSC_ST_NOTDEF   3'h0
`define RSC_ST_READY    3'h1
`define RSC_ST_COMPLETE 3'h2
`define RSC_ST_STOPPED  3'h3
`define RSC_ST_NOTREADY 3'h4
`define RSC_ST_ACTIVE   3'h5

// ctrl bits
`define RSC_CTRL_GO     0
`define RSC_CTRL_SRC_HI 4
`define RSC_CTRL_SRC_LO 2
`define RSC_CTRL_EMB    5
`define RSC_CTRL_STOP   6

// status bits
`define RSC_STS_BUSY    0
`define RSC_STS_DONE    1
`define RSC_STS_REJ     2
`define RSC_STS_PEND    3

`define RSC_RING_PARAM_RST 32'h0000_0004
`define RSC_LOC_PARAM_RST  32'h0000_0002
`endif

// *** rtl/rsc_region_wrap.v ***
// region-confined address: upper bits fixed, lower bits wrap at 2^size_log2 bytes
`timescale 1ns/100ps
`default_nettype none
module rsc_region_wrap #(
  parameter MAX_LOG2 = 24
) (
  input  wire [31:0] base,
  input  wire [4:0]  size_log2,
  input  wire [31:0] offset,
  output wire [31:0] addr
);
  wire [31:0] mask;
  // low bits follow base+offset, high bits stay those of base
  assign mask = (32'h0000_0001 << size_log2) - 32'h0000_0001;
  assign addr = (base & ~mask) | ((base + offset) & mask & 32'hffff_fffc);
endmodule // rsc_region_wrap
`default_nettype wire

// *** rtl/rsc_ring_setup.v ***
// ring setup command interpreter with apb register access
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_ring_setup #(
  parameter NRING = 8
) (
  input  wire        REF_CLK,
  input  wire        RST_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg         FETCH_REQ,
  output reg  [2:0]  FETCH_RING,
  output reg  [31:0] FETCH_ADDR,
  output reg  [31:0] STATUS_ADDR,
  output reg  [31:0] LOCAL_ADDR,
  output reg         COPY_ONLY_IND
);
  // command staging
  reg [31:0] cmd_hi;
  reg [31:0] cmd_lo;
  reg [2:0]  src_ring;
  reg        src_emb;
  reg        pending;
  reg        done;
  reg        rej;
  reg [2:0]  sel;
  // per-ring context
  reg [2:0]  state     [0:NRING-1];
  reg [31:0] rd_ptr    [0:NRING-1];
  reg [31:0] wr_ptr    [0:NRING-1];
  reg [31:0] dst_rd    [0:NRING-1];
  reg [31:0] dst_wr    [0:NRING-1];
  reg [2:0]  dst_state [0:NRING-1];
  reg [31:0] loc_start [0:NRING-1];
  reg [1:0]  ring_mode [0:NRING-1];
  reg [31:0] ring_param;
  reg [31:0] loc_param;
  reg [31:0] rd_off;
  reg [31:0] wr_off;
  integer    i;

  wire        apb_acc  = PSEL & PENABLE & ~PREADY;
  wire        apb_wr   = apb_acc & PWRITE;
  wire [3:0]  opc      = cmd_hi[`RSC_OPC_HI-32:`RSC_OPC_LO-32];
  wire        bit_l    = cmd_hi[`RSC_BIT_L-32];
  wire        bit_i    = cmd_hi[`RSC_BIT_I-32];
  wire        bit_r    = cmd_hi[`RSC_BIT_R-32];
  wire [2:0]  tgt      = cmd_hi[`RSC_RING_HI-32:`RSC_RING_LO-32];
  // pointer fields; low three bits forced zero
  wire [31:0] rd_new   = {cmd_lo[`RSC_PH_HI:`RSC_PH_LO], cmd_hi[`RSC_RDL_HI-32:`RSC_RDL_LO-32], 3'h0};
  wire [31:0] wr_new   = {cmd_lo[`RSC_PH_HI:`RSC_PH_LO], cmd_lo[`RSC_WRL_HI:`RSC_WRL_LO], 3'h0};
  // every ring command carries the fixed tag; define keeps l,i inside its opcode nibble
  wire        hdr_ok   = cmd_hi[31] && (cmd_hi[29:24] == `RSC_CMD_TAG);
  wire        is_def   = hdr_ok && ((opc & 4'h9) == `RSC_OPC_DEF);
  wire        is_dst   = hdr_ok && (opc == `RSC_OPC_DST) && !bit_r;
  wire        is_loc   = hdr_ok && (opc == `RSC_OPC_DST) && bit_r && !bit_l && !bit_i;
  wire        self_tgt = src_emb && (tgt == src_ring);
  // range checks; destination ring 4-5 invalid, others 0-5
  wire        bad_num  = is_dst ? (tgt == 3'h4 || tgt == 3'h5) : (tgt > 3'h5);
  wire        bad_li   = is_def && ((!bit_l && bit_i) || (bit_l && bit_i && tgt > 3'h3));
  wire        reject   = bad_num | self_tgt | bad_li | !(is_def | is_dst | is_loc);
  // define ring waits for a quiescent target ring
  wire        tgt_idle = (state[tgt] == `RSC_ST_STOPPED) || (state[tgt] == `RSC_ST_COMPLETE) ||
                         (state[tgt] == `RSC_ST_NOTDEF);
  wire        can_run  = !is_def || tgt_idle || reject;

  // length codes to region sizes: ring code 0100 -> 128 bytes, local code 010 -> 32K bytes
  wire [4:0]  ring_log2 = {1'b0, ring_param[3:0]} + 5'h03;
  wire [4:0]  loc_log2  = {2'b00, loc_param[2:0]} + 5'h0d;
  wire [31:0] fetch_w;
  wire [31:0] stat_w;
  wire [31:0] loc_w;

  rsc_region_wrap #(.MAX_LOG2(24)) u_rd (
    .base      (rd_ptr[sel]),
    .size_log2 (ring_log2),
    .offset    (rd_off),
    .addr      (fetch_w)
  );
  rsc_region_wrap #(.MAX_LOG2(24)) u_wr (
    .base      (wr_ptr[sel]),
    .size_log2 (ring_log2),
    .offset    (wr_off),
    .addr      (stat_w)
  );
  rsc_region_wrap #(.MAX_LOG2(24)) u_loc (
    .base      (loc_start[sel]),
    .size_log2 (loc_log2),
    .offset    (32'h0000_0000),
    .addr      (loc_w)
  );

  // apb slave: one wait state, answer in second access cycle
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      PREADY     <= 1'b0;
      PSLVERR    <= 1'b0;
      PRDATA     <= 32'h0000_0000;
      cmd_hi     <= 32'h0000_0000;
      cmd_lo     <= 32'h0000_0000;
      src_ring   <= 3'h0;
      src_emb    <= 1'b0;
      sel        <= 3'h0;
      ring_param <= `RSC_RING_PARAM_RST;
      loc_param  <= `RSC_LOC_PARAM_RST;
    end else begin
      PREADY  <= apb_acc;
      PSLVERR <= 1'b0;
      if (apb_wr) begin
        case (PADDR)
          `RSC_ADDR_CMD_HI: begin
            if (!pending) cmd_hi <= PWDATA;
          end
          `RSC_ADDR_CMD_LO: begin
            if (!pending) cmd_lo <= PWDATA;
          end
          `RSC_ADDR_CTRL: begin
            if (!pending) begin
              src_ring <= PWDATA[`RSC_CTRL_SRC_HI:`RSC_CTRL_SRC_LO];
              src_emb  <= PWDATA[`RSC_CTRL_EMB];
            end
          end
          `RSC_ADDR_SEL: sel <= PWDATA[2:0];
          // parameters may only change while the selected ring is not defined
          `RSC_ADDR_RING_PARAM: begin
            if (state[sel] == `RSC_ST_NOTDEF && dst_state[sel] == `RSC_ST_NOTDEF) ring_param <= PWDATA;
            else PSLVERR <= 1'b1;
          end
          `RSC_ADDR_LOC_PARAM: begin
            if (state[sel] == `RSC_ST_NOTDEF) loc_param <= PWDATA;
            else PSLVERR <= 1'b1;
          end
          `RSC_ADDR_STATUS: ;
          default: PSLVERR <= 1'b1;
        endcase
      end else if (apb_acc) begin
        case (PADDR)
          `RSC_ADDR_CMD_HI:     PRDATA <= cmd_hi;
          `RSC_ADDR_CMD_LO:     PRDATA <= cmd_lo;
          `RSC_ADDR_CTRL:       PRDATA <= {26'h0, src_emb, src_ring, 2'b00};
          `RSC_ADDR_STATUS:     PRDATA <= {28'h0, pending, rej, done, pending};
          `RSC_ADDR_SEL:        PRDATA <= {29'h0, sel};
          `RSC_ADDR_RD_PTR:     PRDATA <= rd_ptr[sel];
          `RSC_ADDR_WR_PTR:     PRDATA <= wr_ptr[sel];
          `RSC_ADDR_LOC_START:  PRDATA <= loc_start[sel];
          `RSC_ADDR_RING_PARAM: PRDATA <= ring_param;
          `RSC_ADDR_LOC_PARAM:  PRDATA <= loc_param;
          `RSC_ADDR_STATE:      PRDATA <= {24'h0, 1'b0, dst_state[sel], 1'b0, state[sel]};
          default: begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b1;
          end
        endcase
      end
    end
  end

  // command execution; a go write is accepted when no command is pending and parked until runnable
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      pending <= 1'b0;
      done    <= 1'b0;
      rej     <= 1'b0;
      for (i = 0; i < NRING; i = i + 1) begin
        state[i]     <= `RSC_ST_NOTDEF;
        dst_state[i] <= `RSC_ST_NOTDEF;
        rd_ptr[i]    <= 32'h0000_0000;
        wr_ptr[i]    <= 32'h0000_0000;
        dst_rd[i]    <= 32'h0000_0000;
        dst_wr[i]    <= 32'h0000_0000;
        loc_start[i] <= 32'h0000_0000;
        ring_mode[i] <= 2'b00;
      end
    end else begin
      if (apb_wr && PADDR == `RSC_ADDR_CTRL && PWDATA[`RSC_CTRL_GO] && !pending) begin
        pending <= 1'b1;
        done    <= 1'b0;
        rej     <= 1'b0;
      end else if (pending && can_run) begin
        pending <= 1'b0;
        done    <= 1'b1;
        rej     <= reject;
        if (!reject) begin
          if (is_def) begin
            rd_ptr[tgt]    <= rd_new;
            wr_ptr[tgt]    <= wr_new;
            ring_mode[tgt] <= {bit_l, bit_i};
            state[tgt]     <= bit_r ? `RSC_ST_READY : `RSC_ST_COMPLETE;
          end else if (is_dst) begin
            dst_rd[tgt]    <= rd_new;
            dst_wr[tgt]    <= wr_new;
            dst_state[tgt] <= bit_r ? `RSC_ST_READY : `RSC_ST_NOTREADY;
          end else begin
            loc_start[tgt] <= wr_new;
          end
        end
      end
      // ring stop from software, so a repeating ring can be halted
      if (apb_wr && PADDR == `RSC_ADDR_CTRL && PWDATA[`RSC_CTRL_STOP] && state[sel] != `RSC_ST_NOTDEF) begin
        state[sel] <= `RSC_ST_STOPPED;
      end
    end
  end

  // descriptor walker: fetch at read pointer, status at write pointer, 8 bytes a step
  always @(posedge REF_CLK) begin
    if (!RST_N) begin
      rd_off        <= 32'h0000_0000;
      wr_off        <= 32'h0000_0000;
      FETCH_REQ     <= 1'b0;
      FETCH_RING    <= 3'h0;
      FETCH_ADDR    <= 32'h0000_0000;
      STATUS_ADDR   <= 32'h0000_0000;
      LOCAL_ADDR    <= 32'h0000_0000;
      COPY_ONLY_IND <= 1'b0;
    end else begin
      FETCH_REQ   <= (state[sel] == `RSC_ST_READY);
      FETCH_RING  <= sel;
      FETCH_ADDR  <= fetch_w;
      STATUS_ADDR <= stat_w;
      LOCAL_ADDR  <= loc_w;
      // early-indication rings report only the system-to-local copy
      COPY_ONLY_IND <= (ring_mode[sel] == 2'b11);
      if (pending && can_run && !reject && tgt == sel) begin
        rd_off <= 32'h0000_0000;
        wr_off <= 32'h0000_0000;
      end else if (state[sel] == `RSC_ST_READY) begin
        // offsets wrap inside region via the wrap unit, so ownership bits repeat
        rd_off <= rd_off + 32'h0000_0008;
        wr_off <= wr_off + 32'h0000_0008;
      end
    end
  end
endmodule // rsc_ring_setup
`default_nettype wire

// *** bench/rsc_ring_setup_props.sv ***
// port checker for the ring setup command handler
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.vh"
module rsc_ring_setup_props (
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        FETCH_REQ,
  input wire logic [2:0]  FETCH_RING,
  input wire logic [31:0] FETCH_ADDR,
  input wire logic [31:0] STATUS_ADDR,
  input wire logic [31:0] LOCAL_ADDR,
  input wire logic        COPY_ONLY_IND
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // one wait state, answer is a single-cycle pulse
  property p_answer; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_answer: assert property (p_answer) else $error("answer missing");
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_err; PSLVERR |-> PREADY; endproperty
  a_err: assert property (p_err) else $error("error without answer");
  property p_unmapped; PSEL && PENABLE && !PREADY && PADDR > `RSC_ADDR_STATE |=> PSLVERR; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
  // outputs come out of reset quiet
  property p_quiet; $rose(RST_N) |-> !FETCH_REQ && !COPY_ONLY_IND && !PREADY; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs busy after reset");
  property p_align; FETCH_REQ |-> FETCH_ADDR[2:0] == 3'h0 && STATUS_ADDR[2:0] == 3'h0; endproperty
  a_align: assert property (p_align) else $error("pointer not aligned");
  property p_local; LOCAL_ADDR[2:0] == 3'h0; endproperty
  a_local: assert property (p_local) else $error("local address not aligned");
  property p_early; COPY_ONLY_IND |-> FETCH_RING <= 3'h3; endproperty
  a_early: assert property (p_early) else $error("early indication on receive ring");
  c_err: cover property (PSLVERR);
  c_fetch: cover property (FETCH_REQ);
  c_copy: cover property (COPY_ONLY_IND);
endmodule // rsc_ring_setup_props
bind rsc_ring_setup rsc_ring_setup_props u_props (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .FETCH_REQ(FETCH_REQ),
  .FETCH_RING(FETCH_RING), .FETCH_ADDR(FETCH_ADDR), .STATUS_ADDR(STATUS_ADDR), .LOCAL_ADDR(LOCAL_ADDR),
  .COPY_ONLY_IND(COPY_ONLY_IND));
`default_nettype wire

// *** bench/rsc_host.sv ***
// apb master standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module rsc_host (
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int tmo = 0;
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // request held until pready is seen at an edge; one idle edge after keeps a single assignment per step
  task xfer(input bit w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
endmodule // rsc_host
`default_nettype wire

// *** bench/test_rsc_ring_setup.sv ***
// self-checking bench for the ring setup command handler
`timescale 1ns/100ps
`default_nettype none
`include "rsc_defines.vh"
module test_rsc_ring_setup;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, fetch_req, copy_only, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fetch_addr, status_addr, local_addr, q, rp, wp;
  logic [2:0]  fetch_ring;
  logic [2:0]  st [8];
  logic [13:0] bad [6];
  int          error_cnt, n_compared;
  int          n_wait;
  rsc_ring_setup DUT (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FETCH_REQ(fetch_req),
    .FETCH_RING(fetch_ring), .FETCH_ADDR(fetch_addr), .STATUS_ADDR(status_addr), .LOCAL_ADDR(local_addr),
    .COPY_ONLY_IND(copy_only));
  rsc_host host (.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task conclude;
    error_cnt += host.tmo;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task acc(input bit w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q, e);
    // a transfer that never got its answer ends the run at once
    if (host.tmo != 0) conclude();
  endtask
  // send one command word and go; poll status bounded when asked to wait
  task cmd(input logic [63:0] c, input logic [6:0] ctl, input bit wt);
    int n;
    n = 0;
    acc(1, `RSC_ADDR_CMD_HI, c[63:32]);
    acc(1, `RSC_ADDR_CMD_LO, c[31:0]);
    acc(1, `RSC_ADDR_CTRL, {25'h0, ctl});
    do begin
      acc(0, `RSC_ADDR_STATUS, 0);
      n++;
    end while (wt && q[`RSC_STS_DONE] !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      conclude();
    end
  endtask
  function logic [63:0] mk(input logic [3:0] op, input logic r, input logic [2:0] ring);
    return {8'hfe, op, r, ring, rp[15:3], 3'h0, rp[31:16], wp[15:3], 3'h0};
  endfunction
  task sel_state(input logic [2:0] r);
    acc(1, `RSC_ADDR_SEL, {29'h0, r});
    acc(0, `RSC_ADDR_STATE, 0);
  endtask
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_n = 0;
    foreach (st[i]) st[i] = `RSC_ST_NOTDEF;
    void'($urandom(68));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    sel_state(3'h2);
    chk(q, 0);
    acc(0, 12'h0fc, 0);
    chk(32'(e), 1);
    acc(1, `RSC_ADDR_LOC_PARAM, `RSC_LOC_PARAM_RST);
    chk(32'(e), 0);
    $display("reset test done");
    // plain ring with split read and write pointers in one 128 byte region
    rp = $urandom & 32'hffff_ff80;
    wp = rp | 32'h40;
    cmd(mk(4'h0, 1, 3'h2), 7'h01, 1);
    chk(q[3:0], 4'h2);
    st[2] = `RSC_ST_READY;
    sel_state(3'h2);
    chk(q[2:0], st[2]);
    chk({fetch_req, fetch_ring}, 4'ha);
    // walker steps 8 bytes a cycle; wait for the read pointer to come round again
    n_wait = 0;
    while (fetch_addr !== rp && n_wait < 20) begin
      @(posedge ref_clk);
      n_wait++;
    end
    if (n_wait >= 20) begin
      error_cnt++;
      conclude();
    end
    chk(fetch_addr, rp);
    chk(status_addr, wp);
    @(posedge ref_clk);
    chk(fetch_addr, rp + 32'h8);
    chk(status_addr, wp + 32'h8);
    acc(0, `RSC_ADDR_RD_PTR, 0);
    chk(q, rp);
    acc(1, `RSC_ADDR_RING_PARAM, 32'h5); // refusal expected: ring is defined
    chk(32'(e), 1);
    cmd(mk(4'h0, 0, 3'h1), 7'h01, 1);
    st[1] = `RSC_ST_COMPLETE;
    sel_state(3'h1);
    chk(q[2:0], st[1]);
    $display("define test done");
    // op, ring, ctrl: bad ring, invalid pair, early indication on ring 4, self target, bad destinations
    bad = '{{4'h0, 3'h6, 7'h01}, {4'h2, 3'h0, 7'h01}, {4'h6, 3'h4, 7'h01}, {4'h0, 3'h3, 7'h2d},
            {4'h1, 3'h4, 7'h01}, {4'h1, 3'h5, 7'h01}};
    foreach (bad[i]) begin
      cmd(mk(bad[i][13:10], 0, bad[i][9:7]), bad[i][6:0], 1);
      chk(q[3:0], 4'h6);
    end
    sel_state(3'h0);
    chk(q[2:0], st[0]);
    $display("reject test done");
    cmd(mk(4'h1, 0, 3'h7), 7'h01, 1);
    sel_state(3'h7);
    chk(q[6:4], `RSC_ST_NOTREADY);
    acc(1, `RSC_ADDR_RING_PARAM, 32'h5); // refusal expected: destination defined
    chk(32'(e), 1);
    cmd(mk(4'h0, 1, 3'h0), 7'h01, 1);
    st[0] = `RSC_ST_READY;
    sel_state(3'h0);
    chk(q[2:0], st[0]);
    $display("destination test done");
    rp = 32'h9454_3578;
    wp = rp;
    cmd(mk(4'h1, 1, 3'h3), 7'h01, 1);
    cmd(mk(4'h6, 1, 3'h3), 7'h01, 1);
    sel_state(3'h3);
    chk(32'(copy_only), 1);
    chk(local_addr, rp);
    acc(1, `RSC_ADDR_LOC_PARAM, 32'h3); // refusal expected: ring defined
    chk(32'(e), 1);
    $display("local test done");
    // redefining a ready ring must wait
    cmd(mk(4'h0, 0, 3'h3), 7'h01, 0);
    chk(q[3:1], 3'h4);
    repeat (20) @(posedge ref_clk);
    sel_state(3'h3);
    chk(q[2:0], `RSC_ST_READY);
    // stopping the ring lets the parked define run, ready bit clear
    acc(1, `RSC_ADDR_CTRL, 32'h40);
    acc(0, `RSC_ADDR_STATUS, 0);
    chk(q[3:0], 4'h2);
    sel_state(3'h3);
    chk(q[2:0], `RSC_ST_COMPLETE);
    rst_n <= 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    chk(32'(fetch_req), 0);
    sel_state(3'h3);
    chk(q[2:0], `RSC_ST_NOTDEF);
    acc(0, `RSC_ADDR_STATUS, 0);
    chk(q, 0);
    $display("pending test done");
    conclude();
  end
endmodule // test_rsc_ring_setup
`default_nettype wire
